// [src/veg_gate.v]
// instruction availability gate for the virtualization extension
//
// The APB slave port and the placing of the registers are this design's own decisions.
`timescale 1ns/1ps
`include "veg_defines.vh"

// Operation
// RQ1: entry, save/load, clear-gif, call, inval need enable
// RQ2: secure-init, set-gif need enable or feature bit
// RQ3: leaf one returns presence bit as zero
// RQ4: software leaf range returns no hardware data
// RQ5: guest mode entered only by guest entry
// RQ6: software checks feature and disable before enabling
// RQ7: guest entry needs level zero, protected mode
// RQ8: faulting instruction changes no state
module veg_gate #(
  parameter LOCK_CAP = 1'b0
) (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  input wire insn_valid,
  input wire [2:0] insn_code,
  input wire [1:0] current_privilege_level,
  input wire prot_mode,
  input wire guest_exit,
  output reg insn_done,
  output reg insn_exec,
  output reg undefined_opcode_fault,
  output reg general_protection_fault,
  output reg guest_mode,
  output reg global_intr_flag,
  input wire id_valid,
  input wire [31:0] id_leaf,
  input wire [31:0] id_ecx_raw,
  output reg id_done,
  output reg [31:0] id_ecx,
  output reg id_sw_range,
  output reg irq
);

  // register state
  reg [31:0] ctrl;
  reg [`VEG_EV_W-1:0] irq_stat;
  reg [`VEG_EV_W-1:0] irq_en;

  // decode results, rebuilt every cycle
  reg [`VEG_EV_W-1:0] ev;
  reg [31:0] next_rdata;
  reg next_err;
  reg ok;
  reg gp;

  // named views of the control word, the apb access and the leaf range
  wire virt_enable_bit;
  wire secure_init_feature_bit;
  wire access;
  wire wr;
  wire leaf_sw;

  // enable check per instruction class
  function allowed;
    input [2:0] code;
    input en;
    input sif;
    begin
      // only the late-bound pair accepts the feature bit
      case (code)
        `VEG_OP_SECURE_INIT, `VEG_OP_SET_GIF: allowed = en | sif; // [RQ2]
        default: allowed = en; // [RQ1]
      endcase
    end
  endfunction

  assign virt_enable_bit = ctrl[`VEG_CTRL_ENABLE];
  assign secure_init_feature_bit = ctrl[`VEG_CTRL_SINIT_FEAT];
  // pready is registered, so each access costs one wait state
  assign access = psel & penable & pready;
  assign wr = access & pwrite;
  assign leaf_sw = (id_leaf >= `VEG_LEAF_SW_LO) &&
                   (id_leaf <= `VEG_LEAF_SW_HI);

  // decision for the instruction presented this cycle
  always @* begin
    ok = allowed(insn_code, virt_enable_bit, secure_init_feature_bit);
    gp = 1'b0;
    // guest entry adds the mode and level checks
    if (insn_code == `VEG_OP_GUEST_ENTRY) begin
      if (!prot_mode)
        ok = 1'b0; // [RQ7]
      else if (ok && current_privilege_level != 2'h0)
        gp = 1'b1; // [RQ7]
    end
    // events feed both the fault pulses and the sticky status
    ev = {`VEG_EV_W{1'b0}};
    if (insn_valid) begin
      ev[`VEG_EV_UD] = ~ok;
      ev[`VEG_EV_GP] = gp;
      ev[`VEG_EV_ENTRY] = ok & ~gp & (insn_code == `VEG_OP_GUEST_ENTRY);
    end
  end

  // instruction result and the state it may touch
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      insn_done <= 1'b0;
      insn_exec <= 1'b0;
      undefined_opcode_fault <= 1'b0;
      general_protection_fault <= 1'b0;
      guest_mode <= 1'b0;
      global_intr_flag <= 1'b1;
    end else begin
      // every presented instruction gets exactly one outcome
      insn_done <= insn_valid;
      insn_exec <= insn_valid & ok & ~gp;
      undefined_opcode_fault <= ev[`VEG_EV_UD]; // [RQ1] [RQ2]
      general_protection_fault <= ev[`VEG_EV_GP]; // [RQ7]
      // faulted instructions fall through with no update
      if (insn_valid && ok && !gp) begin // [RQ8]
        case (insn_code)
          `VEG_OP_GUEST_ENTRY: guest_mode <= 1'b1; // [RQ5]
          `VEG_OP_CLR_GIF: global_intr_flag <= 1'b0;
          `VEG_OP_SET_GIF: global_intr_flag <= 1'b1;
          default: global_intr_flag <= global_intr_flag;
        endcase
        // an exit loses to an instruction executing this cycle
      end else if (guest_exit) begin
        guest_mode <= 1'b0;
      end
    end
  end

  // identification answers, one cycle after the query
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      id_done <= 1'b0;
      id_ecx <= 32'h0000_0000;
      id_sw_range <= 1'b0;
    end else begin
      // answers follow the query by exactly one cycle
      id_done <= id_valid;
      id_sw_range <= id_valid & leaf_sw;
      // zero while idle so a stale answer never lingers
      if (!id_valid || leaf_sw)
        id_ecx <= 32'h0000_0000; // [RQ4]
      else if (id_leaf == `VEG_LEAF_BASIC)
        id_ecx <= {1'b0, id_ecx_raw[`VEG_HV_PRESENT_BIT-1:0]}; // [RQ3]
      else
        id_ecx <= id_ecx_raw;
    end
  end

  // read mux and unmapped decode
  always @* begin
    next_rdata = 32'h0000_0000;
    next_err = 1'b0;
    case (paddr)
      `VEG_CTRL_OFS: next_rdata = ctrl;
      `VEG_STAT_OFS: begin
        next_rdata[`VEG_STAT_GUEST] = guest_mode;
        next_rdata[`VEG_STAT_GIF] = global_intr_flag;
        next_rdata[`VEG_STAT_LOCK_CAP] = LOCK_CAP; // [RQ6]
      end
      `VEG_IRQ_STAT_OFS: next_rdata[`VEG_EV_W-1:0] = irq_stat;
      `VEG_IRQ_CLR_OFS: next_rdata = 32'h0000_0000;
      `VEG_IRQ_EN_OFS: next_rdata[`VEG_EV_W-1:0] = irq_en;
      // unmapped offsets read zero and flag an error
      default: next_err = 1'b1;
    endcase
  end

  // apb slave with one wait state
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else begin
      // ready drops after one cycle, so a held access is answered again every second cycle
      pready <= psel & penable & ~pready;
      pslverr <= psel & penable & ~pready & next_err;
      // read data latched in the wait state, stable with ready
      if (psel && penable && !pready && !pwrite)
        prdata <= next_rdata;
    end
  end

  // control register; enable held off while the disable bit is set
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl <= `VEG_CTRL_RESET;
    end else if (wr && paddr == `VEG_CTRL_OFS) begin
      // the disable bit wins within the same write, so enable
      // can never be seen set next to it
      ctrl <= {29'h0000_0000, pwdata[`VEG_CTRL_DISABLE],
               pwdata[`VEG_CTRL_SINIT_FEAT],
               pwdata[`VEG_CTRL_ENABLE] & ~pwdata[`VEG_CTRL_DISABLE]};
    end
  end

  // sticky events; a new event wins over a clear in the same cycle
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_stat <= {`VEG_EV_W{1'b0}};
      irq_en <= {`VEG_EV_W{1'b0}};
      irq <= 1'b0;
    end else begin
      if (wr && paddr == `VEG_IRQ_CLR_OFS)
        irq_stat <= (irq_stat & ~pwdata[`VEG_EV_W-1:0]) | ev;
      else
        irq_stat <= irq_stat | ev;
      // enable mask is plainly writable
      if (wr && paddr == `VEG_IRQ_EN_OFS)
        irq_en <= pwdata[`VEG_EV_W-1:0];
      // registered, so the line trails the status by one cycle
      irq <= |(irq_stat & irq_en);
    end
  end

endmodule // veg_gate

// [src/veg_defines.vh]
// constants for the virtualization extension instruction gate
`ifndef VEG_DEFINES_VH
`define VEG_DEFINES_VH

// apb register byte offsets
`define VEG_CTRL_OFS 12'h000
`define VEG_STAT_OFS 12'h004
`define VEG_IRQ_STAT_OFS 12'h008
`define VEG_IRQ_CLR_OFS 12'h00C
`define VEG_IRQ_EN_OFS 12'h010

// control register fields
`define VEG_CTRL_ENABLE 0
`define VEG_CTRL_SINIT_FEAT 1
`define VEG_CTRL_DISABLE 2
`define VEG_CTRL_RESET 32'h0000_0000

// status register fields
`define VEG_STAT_GUEST 0
`define VEG_STAT_GIF 1
`define VEG_STAT_LOCK_CAP 2

// event bits
`define VEG_EV_UD 0
`define VEG_EV_GP 1
`define VEG_EV_ENTRY 2
`define VEG_EV_W 3

// instruction codes
`define VEG_OP_GUEST_ENTRY 3'h0
`define VEG_OP_STATE_LOAD 3'h1
`define VEG_OP_STATE_SAVE 3'h2
`define VEG_OP_CLR_GIF 3'h3
`define VEG_OP_SET_GIF 3'h4
`define VEG_OP_GUEST_CALL 3'h5
`define VEG_OP_TLB_INVAL 3'h6
`define VEG_OP_SECURE_INIT 3'h7

// identification leaves
`define VEG_LEAF_BASIC 32'h0000_0001
`define VEG_LEAF_SW_LO 32'h4000_0000
`define VEG_LEAF_SW_HI 32'h4000_00FF
`define VEG_HV_PRESENT_BIT 31

`endif

// [bench/veg_gate_asserts.sv]
// port assertions for the instruction gate
`timescale 1ns/1ps
module veg_chk (
  input wire pclk,
  input wire presetn,
  input wire insn_valid,
  input wire prot_mode,
  input wire insn_done,
  input wire insn_exec,
  input wire undefined_opcode_fault,
  input wire general_protection_fault,
  input wire guest_mode,
  input wire global_intr_flag,
  input wire id_valid,
  input wire id_done,
  input wire id_sw_range,
  input wire [2:0] insn_code,
  input wire [1:0] current_privilege_level,
  input wire [31:0] id_leaf,
  input wire [31:0] id_ecx
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // outcome, entry checks, mode flags and identification answers
  property p_done; insn_valid |=> insn_done; endproperty
  a_done: assert property (p_done) else $error("done");
  property p_one; insn_done |-> $onehot({insn_exec,
    undefined_opcode_fault, general_protection_fault}); endproperty
  a_one: assert property (p_one) else $error("outcome");
  property p_real; insn_valid && insn_code == 3'h0 && !prot_mode
    |=> undefined_opcode_fault; endproperty
  a_real: assert property (p_real) else $error("real");
  property p_lvl; insn_valid && insn_code == 3'h0
    && current_privilege_level != 2'h0 |=> !insn_exec; endproperty
  a_lvl: assert property (p_lvl) else $error("level");
  property p_ent; $rose(guest_mode) |-> $past(insn_valid)
    && $past(insn_code) == 3'h0; endproperty
  a_ent: assert property (p_ent) else $error("entry");
  property p_keep; undefined_opcode_fault |-> $stable(guest_mode)
    && $stable(global_intr_flag); endproperty
  a_keep: assert property (p_keep) else $error("state");
  property p_leaf; id_valid && id_leaf == 32'h0000_0001
    |=> id_done && !id_ecx[31]; endproperty
  a_leaf: assert property (p_leaf) else $error("leaf");
  property p_sw; id_valid && id_leaf[31:8] == 24'h40_0000
    |=> id_sw_range && id_ecx == 32'h0000_0000; endproperty
  a_sw: assert property (p_sw) else $error("sw");
  c_ent: cover property (insn_exec && guest_mode);
  c_gp: cover property (general_protection_fault);
  c_sw: cover property (id_sw_range);
endmodule // veg_chk
bind veg_gate veg_chk u_chk (
  .pclk(pclk),
  .presetn(presetn),
  .insn_valid(insn_valid),
  .prot_mode(prot_mode),
  .insn_done(insn_done),
  .insn_exec(insn_exec),
  .undefined_opcode_fault(undefined_opcode_fault),
  .general_protection_fault(general_protection_fault),
  .guest_mode(guest_mode),
  .global_intr_flag(global_intr_flag),
  .id_valid(id_valid),
  .id_done(id_done),
  .id_sw_range(id_sw_range),
  .insn_code(insn_code),
  .current_privilege_level(current_privilege_level),
  .id_leaf(id_leaf),
  .id_ecx(id_ecx)
);

// [bench/veg_sw.sv]
// core register source behind identification queries
`timescale 1ns/1ps
module veg_sw (
  input wire pclk,
  output logic [31:0] id_ecx_raw
);
  // top bit set so clearing shows; low bit toggles to expose stale use
  initial id_ecx_raw = 32'hFFFF_FFFF;
  always @(posedge pclk) id_ecx_raw <= id_ecx_raw ^ 32'h0000_0001;
endmodule // veg_sw

// [bench/test_virt_extension_gating.sv]
// self-checking bench for the instruction gate
`timescale 1ns/1ps
module test_virt_extension_gating;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, err;
  logic insn_valid = 0, prot_mode = 0, id_valid = 0, guest_exit = 0;
  logic [11:0] paddr = 0;
  logic [2:0] insn_code = 0;
  logic [1:0] current_privilege_level = 0;
  logic [31:0] pwdata = 0, id_leaf = 0, prdata, id_ecx_raw, id_ecx, rd;
  logic pready, pslverr, insn_done, insn_exec, undefined_opcode_fault;
  logic general_protection_fault, guest_mode, global_intr_flag, id_done;
  logic id_sw_range, irq;
  int num_errors = 0, tests_run = 0;
  veg_gate u_dut (
    .pclk(pclk),
    .presetn(presetn),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .paddr(paddr),
    .pwdata(pwdata),
    .prdata(prdata),
    .pready(pready),
    .pslverr(pslverr),
    .insn_valid(insn_valid),
    .insn_code(insn_code),
    .current_privilege_level(current_privilege_level),
    .prot_mode(prot_mode),
    .guest_exit(guest_exit),
    .insn_done(insn_done),
    .insn_exec(insn_exec),
    .undefined_opcode_fault(undefined_opcode_fault),
    .general_protection_fault(general_protection_fault),
    .guest_mode(guest_mode),
    .global_intr_flag(global_intr_flag),
    .id_valid(id_valid),
    .id_leaf(id_leaf),
    .id_ecx_raw(id_ecx_raw),
    .id_done(id_done),
    .id_ecx(id_ecx),
    .id_sw_range(id_sw_range),
    .irq(irq)
  );
  veg_sw u_sw (
    .pclk(pclk),
    .id_ecx_raw(id_ecx_raw)
  );
  // 200 MHz core clock
  initial forever #2.5 pclk = ~pclk;
  task automatic chk(input logic ok);
    tests_run++;
    if (ok !== 1'b1) begin
      num_errors++;
      $display("[ERR] %0t mismatch", $time);
    end
  endtask
  task automatic stop_test;
    $display("checks %0d errors %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  // apb transfer held until pready is seen at an edge
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    int n = 0;
    logic seen;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk) penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    seen = pready;
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // one idle edge so a following call never rewrites psel here
    @(posedge pclk);
    if (seen !== 1'b1) begin
      num_errors++;
      stop_test;
    end
  endtask
  // e is {exec, undefined, protection} expected one cycle on
  task automatic ins(input logic [2:0] c, input logic [1:0] l,
                     input logic p, input logic [2:0] e);
    insn_valid <= 1'b1;
    insn_code <= c;
    current_privilege_level <= l;
    prot_mode <= p;
    @(posedge pclk) insn_valid <= 1'b0;
    #1 chk({insn_done, insn_exec, undefined_opcode_fault,
        general_protection_fault} === {1'b1, e});
    @(posedge pclk);
  endtask
  task automatic idq(input logic [31:0] lf, input logic [31:0] m);
    logic [31:0] raw;
    id_valid <= 1'b1;
    id_leaf <= lf;
    #1 raw = id_ecx_raw;
    @(posedge pclk) id_valid <= 1'b0;
    #1 chk(id_done === 1'b1 && id_ecx === (raw & m) &&
           id_sw_range === (m == 0));
    @(posedge pclk);
  endtask
  task automatic t_off;
    apb(1, 12'h010, 32'h0000_0001);
    for (int c = 0; c < 8; c++) ins(c[2:0], 0, 1, 2);
    apb(0, 12'h008, 0);
    chk(rd[0] === 1'b1 && irq === 1'b1);
    apb(1, 12'h00C, 32'h0000_0001);
    apb(0, 12'h020, 0);
    chk(err === 1'b1 && rd === 0 && irq === 1'b0);
    apb(1, 12'h000, 32'h0000_0002);
    ins(4, 0, 1, 4);
    ins(7, 0, 1, 4);
    ins(1, 0, 1, 2);
    $display("t_off done");
  endtask
  task automatic t_on;
    apb(1, 12'h000, 32'h0000_0001);
    ins(0, 0, 0, 2);
    ins(0, 3, 1, 1);
    for (int c = 1; c < 8; c++) ins(c[2:0], 0, 1, 4);
    ins(0, 0, 1, 4);
    apb(1, 12'h000, 32'h0000_0004);
    ins(3, 0, 1, 2);
    chk(guest_mode === 1'b1 && global_intr_flag === 1'b1);
    apb(0, 12'h008, 0);
    chk(rd === 32'h0000_0007);
    // exit pulse returns the core to host mode
    guest_exit <= 1'b1;
    @(posedge pclk) guest_exit <= 1'b0;
    @(posedge pclk);
    chk(guest_mode === 1'b0);
    apb(0, 12'h004, 0);
    chk(rd === 32'h0000_0002);
    $display("t_on done");
  endtask
  // software probe: lock capability, then enable with disable set
  task automatic t_probe;
    apb(0, 12'h004, 0);
    chk(err === 1'b0 && rd === 32'h0000_0002);
    apb(1, 12'h000, 32'h0000_0005);
    apb(0, 12'h000, 0);
    chk(rd === 32'h0000_0004);
    ins(0, 0, 1, 2);
    $display("t_probe done");
  endtask
  task automatic t_id;
    idq(32'h0000_0001, 32'h7FFF_FFFF);
    idq(32'h4000_0000, 0);
    idq(32'h4000_00FF, 0);
    idq(32'h4000_0100, 32'hFFFF_FFFF);
    $display("t_id done");
  endtask
  initial begin
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_off;
    t_probe;
    t_on;
    t_id;
    stop_test;
  end
endmodule // test_virt_extension_gating
